// ===== frame_pkg.sv
/*
  Constants and carrier types for the periodic transmission status frame builder.
  Assumes a 20 MHz system clock and a CAN controller that takes whole frames.
*/
`default_nettype none
package frame_pkg;
  // ==========================================================================
  // identifier
  localparam logic [4:0]  PRIO_FIELD   = 5'h0C;
  localparam logic [15:0] PGN_VALUE    = 16'hF002;
  localparam logic [7:0]  SRC_ADDR     = 8'h03;
  localparam logic [28:0] FRAME_ID     = {PRIO_FIELD, PGN_VALUE, SRC_ADDR};
  localparam logic [3:0]  FRAME_DLC    = 4'h8;
  // ==========================================================================
  // payload field codes
  localparam logic [1:0]  BITS_ONES    = 2'h3;
  localparam logic [7:0]  BYTE_ONES    = 8'hFF;
  localparam logic [15:0] SPEED_FAULT  = 16'hFFFE;
  localparam logic [15:0] SPEED_NOSUP  = 16'hFFFF;
  // ==========================================================================
  // timing
  localparam int CLK_HZ       = 20000000;
  localparam int PERIOD_MS    = 10;
  localparam int PERIOD_CYC   = CLK_HZ / 1000 * PERIOD_MS;
  // ==========================================================================
  // register map (word byte addresses)
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_COUNT   = 4'h8;
  localparam int          CTRL_EN_BIT  = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h00000001;
  localparam int FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {
    SPEED_OK    = 2'h0,
    SPEED_FLT   = 2'h1,
    SPEED_UNSUP = 2'h2
  } speed_status_t;

  typedef struct packed {
    logic [15:0]   speed;
    speed_status_t status;
  } speed_sample_t;

  typedef struct packed {
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } can_frame_t;
endpackage : frame_pkg
`default_nettype wire

// ===== frame_fifo.sv
/*
  Synchronous valid/ready FIFO with parameter width and depth.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              pop  = out_ready_i && (cnt_reg != '0);

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rd_reg];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  wire do_push = in_valid_i && in_ready_o;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(pop);
    end
  end
endmodule : frame_fifo
`default_nettype wire

// ===== status_frame_builder.sv
/*
  Periodic transmission status frame builder with a Wishbone register slave.
  Assumes speed/lockup inputs from logic on clk_i and a CAN controller
  that pops complete frames from a valid/ready port.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: frame sent extended, 29-bit identifier hex CF00203.
// RULE_02: top identifier bits 01100, priority three.
// RULE_03: identifier carries group F002 and sender address 03.
// RULE_04: frame requested every 10 ms with length code 8.
// RULE_05: byte 1 bits 1-2 always ones.
// RULE_06: byte 1 bits 3-4 carry lockup state code.
// RULE_07: byte 1 bits 5-6 shift field always ones.
// RULE_08: byte 1 bits 7-8 always ones.
// RULE_09: output speed 16 bits, low byte 2, high byte 3.
// RULE_10: faulty output speed sends 65534.
// RULE_11: unsupported output speed sends 65535.
// RULE_12: bytes 4 and 5 sent as FF.
// RULE_13: input speed 16 bits, low byte 6, high byte 7.
// RULE_14: faulty input speed sends 65534.
// RULE_15: unsupported input speed sends 65535 not-supported code.
// RULE_16: byte 8 carries controller source address 03.
// RULE_17: all inputs sampled together when a frame is built.
module status_frame_builder #(
  parameter int PERIOD_CYCLES = frame_pkg::PERIOD_CYC,
  parameter int DEPTH         = frame_pkg::FIFO_DEPTH
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // ==========================================================================
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // ==========================================================================
  // measurements
  input  wire frame_pkg::speed_sample_t out_speed_i,
  input  wire frame_pkg::speed_sample_t in_speed_i,
  input  wire logic [1:0]              lockup_state_i,
  // ==========================================================================
  // can controller side
  output frame_pkg::can_frame_t        tx_frame_o,
  output logic                         tx_valid_o,
  input  wire logic                    tx_ready_i
);
  localparam int CW = $clog2(PERIOD_CYCLES + 1);
  localparam int FW = $bits(frame_pkg::can_frame_t);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUILD = 3'b010,
    ST_PUSH  = 3'b100
  } build_state_t;

  // ==========================================================================
  // field encoding
  function automatic logic [15:0] speed_code(input frame_pkg::speed_sample_t s);
    unique case (s.status)
      frame_pkg::SPEED_FLT:   speed_code = frame_pkg::SPEED_FAULT; // RULE_10 RULE_14
      frame_pkg::SPEED_UNSUP: speed_code = frame_pkg::SPEED_NOSUP; // RULE_11 RULE_15
      default:                speed_code = s.speed;
    endcase
  endfunction : speed_code

  // ==========================================================================
  // registers
  logic                    enable_reg;
  logic [31:0]             sent_reg;
  logic [31:0]             drop_reg;
  logic [CW-1:0]           tick_reg;
  build_state_t            state_reg;
  frame_pkg::speed_sample_t out_s_reg;
  frame_pkg::speed_sample_t in_s_reg;
  logic [1:0]              lock_reg;
  frame_pkg::can_frame_t   build_reg;
  logic                    ack_reg;
  logic [31:0]             rdat_reg;

  // ==========================================================================
  // period divider
  wire tick_hit = (tick_reg == CW'(PERIOD_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_reg || tick_hit) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 1'b1; // RULE_04
    end
  end

  // ==========================================================================
  // frame assembly
  wire       fifo_in_ready;
  wire [7:0] byte1 = {frame_pkg::BITS_ONES,           // RULE_08
                      frame_pkg::BITS_ONES,           // RULE_07
                      lock_reg,                       // RULE_06
                      frame_pkg::BITS_ONES};          // RULE_05
  wire [15:0] out_code = speed_code(out_s_reg);
  wire [15:0] in_code  = speed_code(in_s_reg);
  // byte 1 in data[7:0], byte 8 in data[63:56]
  wire [63:0] payload = {frame_pkg::SRC_ADDR,          // RULE_16
                         in_code[15:8], in_code[7:0],  // RULE_13
                         frame_pkg::BYTE_ONES,         // RULE_12
                         frame_pkg::BYTE_ONES,         // RULE_12
                         out_code[15:8], out_code[7:0], // RULE_09
                         byte1};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:  if (enable_reg && tick_hit) state_reg <= ST_BUILD;
        ST_BUILD: state_reg <= ST_PUSH;
        ST_PUSH:  state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_s_reg <= '0;
      in_s_reg  <= '0;
      lock_reg  <= frame_pkg::BITS_ONES;
    end else if (state_reg == ST_IDLE && enable_reg && tick_hit) begin
      out_s_reg <= out_speed_i; // RULE_17
      in_s_reg  <= in_speed_i;  // RULE_17
      lock_reg  <= lockup_state_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      build_reg <= '0;
    end else if (state_reg == ST_BUILD) begin
      build_reg.id   <= frame_pkg::FRAME_ID;  // RULE_01 RULE_02 RULE_03
      build_reg.dlc  <= frame_pkg::FRAME_DLC; // RULE_04
      build_reg.data <= payload;
    end
  end

  // ==========================================================================
  // output buffer
  wire                  push_req = (state_reg == ST_PUSH);
  wire [FW-1:0]         fifo_q;
  wire                  fifo_q_valid;
  wire                  out_take = tx_valid_o && tx_ready_i;
  wire                  out_free = !tx_valid_o || tx_ready_i;

  frame_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (build_reg),
    .in_valid_i  (push_req),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_q),
    .out_valid_o (fifo_q_valid),
    .out_ready_i (out_free)
  );

  // registered output stage fed from the fifo head
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_frame_o <= '0;
    end else if (out_free) begin
      tx_valid_o <= fifo_q_valid;
      // empty head is never loaded, so the frame port stays defined
      if (fifo_q_valid) begin
        tx_frame_o <= fifo_q;
      end
    end
  end

  // ==========================================================================
  // counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sent_reg <= '0;
      drop_reg <= '0;
    end else begin
      if (out_take) begin
        sent_reg <= sent_reg + 32'h00000001;
      end
      if (push_req && !fifo_in_ready) begin
        drop_reg <= drop_reg + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // wishbone register access
  wire wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
  // write commits on the edge where the master sees ack
  wire wb_done    = wb_cyc_i && wb_stb_i && ack_reg;
  wire wr_ctrl    = wb_done && wb_we_i && (wb_adr_i == frame_pkg::ADDR_CTRL) && wb_sel_i[0];
  wire [31:0] rd_mux =
      (wb_adr_i == frame_pkg::ADDR_CTRL)   ? {31'h00000000, enable_reg} :
      (wb_adr_i == frame_pkg::ADDR_STATUS) ? {drop_reg[15:0], 11'h000,
                                              fifo_q_valid, !fifo_in_ready, state_reg} :
      (wb_adr_i == frame_pkg::ADDR_COUNT)  ? sent_reg : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= frame_pkg::CTRL_RESET[frame_pkg::CTRL_EN_BIT];
      ack_reg    <= 1'b0;
      rdat_reg   <= '0;
    end else begin
      ack_reg  <= wb_req;
      rdat_reg <= rd_mux;
      if (wr_ctrl) begin
        enable_reg <= wb_dat_i[frame_pkg::CTRL_EN_BIT];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
endmodule : status_frame_builder
`default_nettype wire

// ===== frame_builder_chk.sv
/*
  Port checker for the status frame builder.
  Assumes a bind onto status_frame_builder and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_builder_chk #(
  parameter int PERIOD_CYCLES = 50
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  wb_we_i,
  input wire logic [3:0]            wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire frame_pkg::can_frame_t tx_frame_o,
  input wire logic                  tx_valid_o,
  input wire logic                  tx_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // enable shadow, idle span between frames while enabled
  logic en_reg;
  int   idle_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'b1;
    end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == frame_pkg::ADDR_CTRL) begin
      en_reg <= wb_dat_i[0];
    end
  end
  always_ff @(posedge clk_i) begin
    idle_reg <= (rst_i || tx_valid_o || !en_reg) ? 0 : idle_reg + 1;
  end
  // ==========================================================================
  // assertions
  a_id_fixed: assert property (tx_valid_o |-> tx_frame_o.id == 29'h0CF00203)
    else $error("frame identifier wrong");
  a_dlc_eight: assert property (tx_valid_o |-> tx_frame_o.dlc == 4'h8)
    else $error("frame length code wrong");
  a_period_bound: assert property (idle_reg <= 2 * PERIOD_CYCLES)
    else $error("frame period too long");
  a_byte1_low: assert property (tx_valid_o |-> tx_frame_o.data[1:0] == 2'h3)
    else $error("byte 1 low bits not ones");
  a_shift_ones: assert property (tx_valid_o |-> tx_frame_o.data[5:4] == 2'h3)
    else $error("shift field not ones");
  a_byte1_high: assert property (tx_valid_o |-> tx_frame_o.data[7:6] == 2'h3)
    else $error("byte 1 high bits not ones");
  a_reserved_ff: assert property (tx_valid_o |-> tx_frame_o.data[39:24] == 16'hFFFF)
    else $error("bytes 4 and 5 not ones");
  a_src_byte: assert property (tx_valid_o |-> tx_frame_o.data[63:56] == 8'h03)
    else $error("byte 8 address wrong");
  a_frame_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o))
    else $error("frame changed before taken");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : frame_builder_chk
`default_nettype wire

// ===== can_tx_model.sv
/*
  CAN controller stand-in that accepts frames, sometimes slowly.
  Assumes the builder's valid/ready frame port on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module can_tx_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  output logic      ready_o
);
  // ready drops at random, stays low while stalled
  always @(posedge clk_i) begin
    ready_o <= !rst_i && !stall_i && ($urandom_range(3) != 0);
  end
endmodule : can_tx_model
`default_nettype wire

// ===== test_status_frame_builder.sv
/*
  Self-checking bench for the status frame builder.
  Assumes frame_pkg, the builder, its FIFO, the CAN model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_status_frame_builder;
  localparam int P = 50;
  logic                    clk_i = 0, rst_i = 1, stall = 0;
  logic                    wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, ready;
  logic [3:0]              wb_adr = 0, wb_sel = 0;
  logic [31:0]             wb_dat = 0, wb_rd;
  logic [1:0]              lock = 0;
  frame_pkg::speed_sample_t osp = 0, isp = 0;
  frame_pkg::can_frame_t   frame;
  logic                    valid;
  int                      bad_count = 0, n_checks = 0, n_taken = 0;
  frame_pkg::can_frame_t   frame_q[$];
  frame_pkg::can_frame_t   exp_frame;
  logic [63:0]             rd_q[$];
  status_frame_builder #(.PERIOD_CYCLES(P), .DEPTH(8)) status_frame_builder_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .out_speed_i(osp), .in_speed_i(isp),
    .lockup_state_i(lock), .tx_frame_o(frame), .tx_valid_o(valid), .tx_ready_i(ready));
  can_tx_model can_tx_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(ready));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [96:0] got, input logic [96:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // ==========================================================================
  // result watcher
  always @(posedge clk_i) begin
    if (!rst_i && valid === 1'b1 && ready === 1'b1) begin
      n_taken++;
      exp_frame = (frame_q.size() > 0) ? frame_q.pop_front() : '0;
      check(frame, exp_frame);
    end
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      check(97'(wb_rd & rd_q[0][63:32]), 97'(rd_q[0][31:0]));
      void'(rd_q.pop_front());
    end
  end
  // ==========================================================================
  // bus and stimulus tasks
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    int t;
    @(posedge clk_i);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= dat;
    t = 0;
    do @(posedge clk_i); while (wb_ack !== 1'b1 && ++t < 100);
    check(97'(wb_ack), 97'(1));
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask : wb
  task automatic rd(input logic [3:0] adr, input logic [31:0] m, input logic [31:0] e);
    rd_q.push_back({m, e});
    wb(0, adr, 4'hF, 32'h0);
  endtask : rd
  function automatic logic [15:0] fld(frame_pkg::speed_sample_t s);
    if (s.status == frame_pkg::SPEED_FLT) return 16'hFFFE;
    if (s.status == frame_pkg::SPEED_UNSUP) return 16'hFFFF;
    return s.speed;
  endfunction : fld
  task automatic stim(input int i);
    frame_pkg::speed_sample_t o, n;
    logic [1:0] l;
    o = {16'($urandom), 2'(i)};
    n = {16'($urandom), 2'(i >> 2)};
    l = 2'(i + 1);
    osp  <= o;
    isp  <= n;
    lock <= l;
    frame_q.push_back({29'h0CF00203, 4'h8, 8'h03, fld(n), 16'hFFFF, fld(o), 4'hF, l, 2'h3});
  endtask : stim
  // ==========================================================================
  // main sequence
  initial begin
    int k, t;
    void'($urandom(32'h5BEFDFF3));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(frame_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    wb(1, 4'hC, 4'hF, 32'hFFFFFFFF);
    rd(4'hC, 32'hFFFFFFFF, 32'h0);
    wb(1, frame_pkg::ADDR_CTRL, 4'h0, 32'h0);
    rd(frame_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
    wb(1, frame_pkg::ADDR_CTRL, 4'hF, 32'h0);
    rd(frame_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    repeat (3 * P) @(posedge clk_i);
    check(97'(n_taken), 97'(0));
    for (int i = 0; i < 16; i++) begin
      stim(i);
      if (i == 0) wb(1, frame_pkg::ADDR_CTRL, 4'hF, 32'h1);
      k = n_taken;
      t = 0;
      while (n_taken == k && t++ < 3 * P) @(posedge clk_i);
      check(97'(n_taken), 97'(k + 1));
    end
    rd(frame_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'(n_taken));
    stim(16);
    repeat (8) frame_q.push_back(frame_q[0]);
    stall <= 1;
    repeat (12 * P) @(posedge clk_i);
    rd(frame_pkg::ADDR_STATUS, 32'h8, 32'h8);
    wb(1, frame_pkg::ADDR_CTRL, 4'h1, 32'h0);
    stall <= 0;
    repeat (12 * P) @(posedge clk_i);
    rd(frame_pkg::ADDR_STATUS, 32'h8, 32'h0);
    rd(frame_pkg::ADDR_COUNT, 32'hFFFFFFFF, 32'h00000019);
    check(97'(frame_q.size()), 97'(0));
    print_verdict();
  end
  initial begin
    #(6000 * P * 1ns);
    bad_count++;
    print_verdict();
  end
endmodule : test_status_frame_builder
bind status_frame_builder frame_builder_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) frame_builder_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .tx_frame_o(tx_frame_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
`default_nettype wire
